// [oscx_xtal_ctrl.sv]
// The APB interface to the registers was chosen for this implementation.
`include "oscx_params.svh"

module oscx_xtal_ctrl
#(
   parameter int ADDR_WIDTH = 8,
   parameter int STARTUP_WIDTH = 16
)
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_WIDTH-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Live status levels from other clock domains
   input wire logic pll_lock_timeout_in,
   input wire logic pll_lock_fall_in,
   input wire logic pll_lock_rise_in,
   input wire logic brownout_sync_busy_in,
   input wire logic brownout_detected_in,
   input wire logic brownout_ready_in,
   input wire logic fll_ref_stopped_in,
   input wire logic fll_coarse_lock_in,
   input wire logic fll_fine_lock_in,
   input wire logic fll_out_of_bounds_in,
   input wire logic fll_sync_status_in,
   input wire logic rc8m_ready_in,
   input wire logic rc32k_ready_in,
   input wire logic xtal32k_ready_in,
   // Oscillator environment
   input wire logic ultra_low_power_32k_clock_in,
   input wire logic osc_clock_in,
   input wire logic periph_request_in,
   input wire logic standby_in,
   // Analogue oscillator controls and interrupt
   output logic osc_run_out,
   output logic auto_amplitude_gain_out,
   output logic [2:0] osc_gain_out,
   output logic crystal_pad_select_out,
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   localparam int NSYNC = 18;
   localparam int I_ULP = 14;
   localparam int I_OSC = 15;
   localparam int I_REQ = 16;
   localparam int I_STBY = 17;

   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   logic [NSYNC-1:0] nxt_sync1;
   logic [NSYNC-1:0] nxt_sync2;

   // Status levels occupy indices 13..0 in their status bit order
   assign async_in = {standby_in, periph_request_in, osc_clock_in, ultra_low_power_32k_clock_in,
                      pll_lock_timeout_in, pll_lock_fall_in, pll_lock_rise_in,
                      brownout_sync_busy_in, brownout_detected_in, brownout_ready_in,
                      fll_ref_stopped_in, fll_coarse_lock_in, fll_fine_lock_in,
                      fll_out_of_bounds_in, fll_sync_status_in,
                      rc8m_ready_in, rc32k_ready_in, xtal32k_ready_in};

   // Two flops per bit; only the second stage is read by logic
   generate
      for (genvar i = 0; i < NSYNC; i++)
      begin : g_sync
         always_comb
         begin
            nxt_sync1[i] = async_in[i];
            nxt_sync2[i] = sync1_ff[i];
         end

         always_ff @(posedge clock_in or negedge reset_n_in)
         begin
            if (!reset_n_in)
            begin
               sync1_ff[i] <= 1'b0;
               sync2_ff[i] <= 1'b0;
            end
            else
            begin
               sync1_ff[i] <= nxt_sync1[i];
               sync2_ff[i] <= nxt_sync2[i];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Slow clock edge enables

   logic ulp_prev_ff;
   logic osc_prev_ff;
   logic ulp_tick;
   logic osc_tick;

   // The slow clocks are sampled, so each rising edge becomes a one-cycle enable
   assign ulp_tick = sync2_ff[I_ULP] & ~ulp_prev_ff; // see [R13]
   assign osc_tick = sync2_ff[I_OSC] & ~osc_prev_ff; // see [R14]

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ulp_prev_ff <= 1'b0;
         osc_prev_ff <= 1'b0;
      end
      else
      begin
         ulp_prev_ff <= sync2_ff[I_ULP];
         osc_prev_ff <= sync2_ff[I_OSC];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB register file

   logic [15:0] ctrl_ff;
   logic [15:0] nxt_ctrl;
   logic irq_enable_ff;
   logic nxt_irq_enable;
   logic irq_flag_ff;
   logic nxt_irq_flag;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pslverr_ff;
   logic nxt_pslverr;
   logic [31:0] status_word;
   logic xtal_ready_ff;
   logic nxt_xtal_ready;
   logic setup_phase;
   logic wr_access;
   logic hit;
   logic [7:0] addr8;

   assign addr8 = 8'(paddr_in);
   assign setup_phase = psel_in & ~penable_in;
   assign wr_access = psel_in & penable_in & pwrite_in;
   assign hit = (addr8 == `OSCX_IRQ_ENABLE_OFS) || (addr8 == `OSCX_IRQ_FLAG_OFS) ||
                (addr8 == `OSCX_STATUS_OFS) || (addr8 == `OSCX_CTRL_OFS);

   // Live status; reserved upper bits stay zero
   always_comb
   begin
      status_word = 32'h00000000; // see [R3]
      status_word[`OSCX_STATUS_TOP:`OSCX_PLL_LO] = sync2_ff[13:11]; // see [R4]
      status_word[`OSCX_LEVELS_TOP:1] = sync2_ff[10:0]; // see [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12]
      status_word[`OSCX_XTAL_READY_BIT] = xtal_ready_ff; // see [R12]
   end

   // Read data is captured in the setup cycle so it leaves a flop; zero wait states
   always_comb
   begin
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      if (setup_phase)
      begin
         nxt_pslverr = ~hit;
         if (pwrite_in)
         begin
            nxt_prdata = 32'h00000000;
         end
         else if (addr8 == `OSCX_IRQ_ENABLE_OFS)
         begin
            nxt_prdata = {31'h00000000, irq_enable_ff};
         end
         else if (addr8 == `OSCX_IRQ_FLAG_OFS)
         begin
            nxt_prdata = {31'h00000000, irq_flag_ff};
         end
         else if (addr8 == `OSCX_STATUS_OFS)
         begin
            nxt_prdata = status_word;
         end
         else if (addr8 == `OSCX_CTRL_OFS)
         begin
            nxt_prdata = {16'h0000, ctrl_ff}; // see [R3]
         end
         else
         begin
            nxt_prdata = 32'h00000000;
         end
      end
   end

   // Writes land at the access edge; reserved control bits are masked off
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_irq_enable = irq_enable_ff;
      if (wr_access)
      begin
         if (addr8 == `OSCX_IRQ_ENABLE_OFS)
         begin
            nxt_irq_enable = pwdata_in[0];
         end
         else if (addr8 == `OSCX_CTRL_OFS)
         begin
            nxt_ctrl = pwdata_in[15:0] & `OSCX_CTRL_WMASK; // see [R3]
         end
      end
   end

   // Ready flag: a rising edge of ready beats a same-cycle write-one clear
   always_comb
   begin
      nxt_irq_flag = irq_flag_ff;
      if (wr_access && (addr8 == `OSCX_IRQ_FLAG_OFS) && pwdata_in[0])
      begin
         nxt_irq_flag = 1'b0; // see [R2]
      end
      if (nxt_xtal_ready && !xtal_ready_ff)
      begin
         nxt_irq_flag = 1'b1; // see [R1]
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ctrl_ff <= `OSCX_CTRL_RESET; // see [R17]
         irq_enable_ff <= 1'b0;
         irq_flag_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         irq_enable_ff <= nxt_irq_enable;
         irq_flag_ff <= nxt_irq_flag;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata_out = prdata_ff;
   assign pslverr_out = pslverr_ff;
   assign pready_out = 1'b1;
   assign irq_out = irq_flag_ff & irq_enable_ff; // see [R1]

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator run decision and startup sequencing

   logic osc_run;
   logic [STARTUP_WIDTH-1:0] count_ff;
   logic [STARTUP_WIDTH-1:0] nxt_count;
   logic [1:0] sync_cnt_ff;
   logic [1:0] nxt_sync_cnt;
   oscx_pkg::oscx_state_t state_ff;
   oscx_pkg::oscx_state_t nxt_state;

   // Enable, then on-request gating, then standby gating
   always_comb
   begin
      osc_run = ctrl_ff[`OSCX_ENABLE_BIT]; // see [R20]
      if (ctrl_ff[`OSCX_ON_REQUEST_BIT] && !sync2_ff[I_REQ])
      begin
         osc_run = 1'b0; // see [R17]
      end
      if (sync2_ff[I_STBY] && !ctrl_ff[`OSCX_KEEP_SLEEP_BIT])
      begin
         osc_run = 1'b0; // see [R18]
      end
   end

   // Startup counts 2**n slow ticks, then 3 oscillator edges, then ready
   always_comb
   begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      nxt_sync_cnt = sync_cnt_ff;
      nxt_xtal_ready = 1'b0;
      if (!osc_run)
      begin
         nxt_state = oscx_pkg::OSCX_OFF; // see [R21]
      end
      else
      begin
         case (state_ff)
            oscx_pkg::OSCX_OFF:
            begin
               nxt_state = oscx_pkg::OSCX_STARTUP; // see [R20]
               nxt_count = STARTUP_WIDTH'(1) << ctrl_ff[`OSCX_STARTUP_HI:`OSCX_STARTUP_LO]; // see [R13]
            end
            oscx_pkg::OSCX_STARTUP:
            begin
               if (ulp_tick)
               begin
                  nxt_count = count_ff - STARTUP_WIDTH'(1);
                  if (count_ff == STARTUP_WIDTH'(1))
                  begin
                     nxt_state = oscx_pkg::OSCX_SYNC;
                     nxt_sync_cnt = `OSCX_SYNC_CYCLES; // see [R14]
                  end
               end
            end
            oscx_pkg::OSCX_SYNC:
            begin
               if (osc_tick)
               begin
                  nxt_sync_cnt = sync_cnt_ff - 2'h1;
                  if (sync_cnt_ff == 2'h1)
                  begin
                     nxt_state = oscx_pkg::OSCX_READY; // see [R14]
                     nxt_xtal_ready = 1'b1;
                  end
               end
            end
            default:
            begin
               nxt_xtal_ready = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_ff <= oscx_pkg::OSCX_OFF;
         count_ff <= '0;
         sync_cnt_ff <= 2'h0;
         xtal_ready_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
         sync_cnt_ff <= nxt_sync_cnt;
         xtal_ready_ff <= nxt_xtal_ready;
      end
   end

   // Analogue controls; the gain field is stored but the oscillator ignores it under auto gain
   assign osc_run_out = osc_run;
   assign auto_amplitude_gain_out = ctrl_ff[`OSCX_AUTO_GAIN_BIT]; // see [R15]
   assign osc_gain_out = ctrl_ff[`OSCX_GAIN_HI:`OSCX_GAIN_LO]; // see [R16]
   assign crystal_pad_select_out = ctrl_ff[`OSCX_PAD_SEL_BIT]; // see [R19]

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!reset_n_in);

   property p_flag_on_rise;
      $rose(xtal_ready_ff) |-> irq_flag_ff && irq_out == irq_enable_ff;
   endproperty
   a_flag_on_rise: assert property (p_flag_on_rise) else $error("ready rise did not set flag"); // see [R1]

   property p_w1c;
      wr_access && addr8 == `OSCX_IRQ_FLAG_OFS && pwdata_in[0] && !(nxt_xtal_ready && !xtal_ready_ff)
         |=> !irq_flag_ff;
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear flag"); // see [R2]

   property p_w0_keeps;
      wr_access && addr8 == `OSCX_IRQ_FLAG_OFS && !pwdata_in[0] && irq_flag_ff |=> irq_flag_ff;
   endproperty
   a_w0_keeps: assert property (p_w0_keeps) else $error("write zero changed flag"); // see [R2]

   property p_reserved_zero;
      psel_in && penable_in && !pwrite_in && addr8 == `OSCX_STATUS_OFS |-> prdata_out[31:18] == 14'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits not zero"); // see [R3]

   property p_ctrl_reserved;
      ctrl_ff[5:3] == 3'h0 && ctrl_ff[0] == 1'b0;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved control bits set"); // see [R3]

   property p_sync_wait;
      $rose(xtal_ready_ff) |-> $past(state_ff) == oscx_pkg::OSCX_SYNC && $past(sync_cnt_ff) == 2'h1;
   endproperty
   a_sync_wait: assert property (p_sync_wait) else $error("ready without oscillator sync"); // see [R14]

   property p_on_request;
      ctrl_ff[`OSCX_ON_REQUEST_BIT] && !sync2_ff[I_REQ] |-> !osc_run_out ##1 !xtal_ready_ff;
   endproperty
   a_on_request: assert property (p_on_request) else $error("oscillator ran without request"); // see [R17]

   property p_standby_stop;
      sync2_ff[I_STBY] && !ctrl_ff[`OSCX_KEEP_SLEEP_BIT] |-> !osc_run_out;
   endproperty
   a_standby_stop: assert property (p_standby_stop) else $error("oscillator ran in standby"); // see [R18]

   property p_ready_falls;
      !osc_run_out |=> !xtal_ready_ff && state_ff == oscx_pkg::OSCX_OFF;
   endproperty
   a_ready_falls: assert property (p_ready_falls) else $error("ready stayed while stopped"); // see [R21]

   property p_startup_load;
      state_ff == oscx_pkg::OSCX_OFF && osc_run_out
         |=> count_ff == STARTUP_WIDTH'(1) << $past(ctrl_ff[`OSCX_STARTUP_HI:`OSCX_STARTUP_LO]);
   endproperty
   a_startup_load: assert property (p_startup_load) else $error("startup count wrong"); // see [R13]

endmodule

// [oscx_params.svh]
`ifndef OSCX_PARAMS_SVH
`define OSCX_PARAMS_SVH
// Behaviour
// [R1] Oscillator-ready rising edge sets the ready flag; flag and enable raise the interrupt.
// [R2] Writing one clears the ready flag; writing zero leaves it alone.
// [R3] Status bits 31:18 and control bits 5:3 read zero; software writes zero.
// [R4] Status 17/16/15 report PLL lock timeout, lock fall and lock rise.
// [R5] Status 11 is one while brown-out settings synchronisation is busy.
// [R6] Status 10 is one when the brown-out detector sees low I/O supply.
// [R7] Status 9 is one when the brown-out detector is ready.
// [R8] Status 8 is one when the FLL reference clock has stopped.
// [R9] Status 7 and 6 report FLL coarse lock and fine lock.
// [R10] Status 5 is one when the FLL reports out of bounds.
// [R11] Status 4 mirrors the FLL synchronisation status level.
// [R12] Status 3..0 report 8 MHz RC, 32 kHz RC, 32 kHz crystal, crystal ready.
// [R13] Control 15:12 picks a startup of 2**n ultra-low-power 32 kHz clock cycles.
// [R14] After startup count, wait 3 oscillator clock cycles before ready.
// [R15] Control bit 11 enables automatic amplitude gain control.
// [R16] Gain field 10:8 levels 0..4; ignored while automatic gain is on.
// [R17] On-demand bit 7 runs oscillator only on request; resets to one.
// [R18] In standby the oscillator stops unless run-in-standby bit 6 is set.
// [R19] Control bit 2 selects crystal across pads or external clock on input pad.
// [R20] Control bit 1 enables the oscillator and starts the startup count.
// [R21] Ready falls whenever the oscillator is stopped, so restarts rise afresh.

// Register byte offsets
`define OSCX_IRQ_ENABLE_OFS 8'h00
`define OSCX_IRQ_FLAG_OFS 8'h08
`define OSCX_STATUS_OFS 8'h0C
`define OSCX_CTRL_OFS 8'h10

// Control register fields
`define OSCX_CTRL_RESET 16'h0080
`define OSCX_CTRL_WMASK 16'hFFC6
`define OSCX_STARTUP_HI 15
`define OSCX_STARTUP_LO 12
`define OSCX_AUTO_GAIN_BIT 11
`define OSCX_GAIN_HI 10
`define OSCX_GAIN_LO 8
`define OSCX_ON_REQUEST_BIT 7
`define OSCX_KEEP_SLEEP_BIT 6
`define OSCX_PAD_SEL_BIT 2
`define OSCX_ENABLE_BIT 1

// Status register fields
`define OSCX_STATUS_TOP 17
`define OSCX_PLL_LO 15
`define OSCX_LEVELS_TOP 11
`define OSCX_XTAL_READY_BIT 0

// Oscillator clock cycles between startup expiry and ready
`define OSCX_SYNC_CYCLES 2'h3
`endif

// [oscx_pkg.sv]
package oscx_pkg;
   // Oscillator sequencing states
   typedef enum logic [1:0]
   {
      OSCX_OFF,
      OSCX_STARTUP,
      OSCX_SYNC,
      OSCX_READY
   } oscx_state_t;
endpackage

// [oscx_osc_model.sv]
module oscx_osc_model
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic osc_run_in,
   output logic ulp_clock_out,
   output logic osc_clock_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ulp_cnt_ff;
   logic [1:0] osc_cnt_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Slow clock runs free; oscillator clock only while powered, else parked low
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ulp_cnt_ff <= 2'h0;
         ulp_clock_out <= 1'b0;
         osc_cnt_ff <= 2'h0;
         osc_clock_out <= 1'b0;
      end
      else
      begin
         ulp_cnt_ff <= ulp_cnt_ff + 2'h1;
         if (ulp_cnt_ff == 2'h3)
         begin
            ulp_clock_out <= !ulp_clock_out;
         end
         if (!osc_run_in)
         begin
            osc_cnt_ff <= 2'h0;
            osc_clock_out <= 1'b0;
         end
         else if (osc_cnt_ff == 2'h2)
         begin
            osc_cnt_ff <= 2'h0;
            osc_clock_out <= !osc_clock_out;
         end
         else
         begin
            osc_cnt_ff <= osc_cnt_ff + 2'h1;
         end
      end
   end
endmodule

// [tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in, reset_n_in, psel, penable, pwrite, req, stby, last_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata_out, rdata;
   logic pready_out, pslverr_out, osc_run_out, auto_out, pad_out, irq_out, ulp_clk, osc_clk;
   logic [2:0] gain_out;
   logic [13:0] sts;
   int n_errors, check_count, cyc;

   oscx_xtal_ctrl u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .pll_lock_timeout_in(sts[13]),
      .pll_lock_fall_in(sts[12]), .pll_lock_rise_in(sts[11]), .brownout_sync_busy_in(sts[10]),
      .brownout_detected_in(sts[9]), .brownout_ready_in(sts[8]), .fll_ref_stopped_in(sts[7]),
      .fll_coarse_lock_in(sts[6]), .fll_fine_lock_in(sts[5]), .fll_out_of_bounds_in(sts[4]),
      .fll_sync_status_in(sts[3]), .rc8m_ready_in(sts[2]), .rc32k_ready_in(sts[1]),
      .xtal32k_ready_in(sts[0]), .ultra_low_power_32k_clock_in(ulp_clk), .osc_clock_in(osc_clk),
      .periph_request_in(req), .standby_in(stby), .osc_run_out(osc_run_out),
      .auto_amplitude_gain_out(auto_out), .osc_gain_out(gain_out), .crystal_pad_select_out(pad_out),
      .irq_out(irq_out));

   oscx_osc_model u_osc (.clock_in(clock_in), .reset_n_in(reset_n_in), .osc_run_in(osc_run_out),
      .ulp_clock_out(ulp_clk), .osc_clock_out(osc_clk));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and run limit; the limit guards against a pready that never comes
   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = !clock_in;
   end

   always @(posedge clock_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and comparisons
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Expected status word from the live levels and the ready bit
   function automatic logic [31:0] sts_word(input logic [13:0] s, input logic rdy);
      return {14'h0, s[13:11], 3'h0, s[10:0], rdy};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB master: request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge clock_in);
      penable <= 1'b1;
      @(posedge clock_in);
      // No limit of its own; pready seen high, or else the bench timeout, ends this wait
      while (pready_out !== 1'b1)
      begin
         @(posedge clock_in);
      end
      rdata = prdata_out;
      last_err = pslverr_out;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      chk(what, exp, rdata);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask

   // Poll the ready bit under a bound
   task automatic wait_ready();
      int k;
      k = 0;
      rdata = 32'h0;
      while (rdata[0] !== 1'b1 && k < 300)
      begin
         apb(1'b0, 8'h0C, 32'h0);
         k++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      reset_n_in = 1'b0;
      {psel, penable, pwrite, req, stby} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sts = 14'h0;
      tick(12);
      reset_n_in <= 1'b1;
      rd_chk("status reset", 8'h0C, 32'h00000000);
      rd_chk("ctrl reset", 8'h10, 32'h00000080);
      for (int i = 0; i < 15; i++)
      begin
         sts <= (i == 14) ? 14'h3FFF : 14'h1 << i;
         tick(4);
         rd_chk("status levels", 8'h0C, sts_word(sts, 1'b0));
      end
      // Software keeps reserved bits at zero, even on a read-only word
      apb(1'b1, 8'h0C, 32'h00038FFF);
      rd_chk("status write ignored", 8'h0C, sts_word(14'h3FFF, 1'b0));
      sts <= 14'h0;
      apb(1'b1, 8'h10, 32'h0000FCC4);
      rd_chk("ctrl fields", 8'h10, 32'h0000FCC4);
      chk("auto gain", 32'h1, {31'h0, auto_out});
      chk("pad select", 32'h1, {31'h0, pad_out});
      // Register outputs follow the control register directly, settling at the edge where the write lands
      for (int g = 0; g < 5; g++)
      begin
         apb(1'b1, 8'h10, 32'(g) << 8);
         tick(1);
         chk("gain", 32'(g), {29'h0, gain_out});
      end
      chk("auto off", 32'h0, {31'h0, auto_out});
      chk("pad off", 32'h0, {31'h0, pad_out});
      // Startup of four slow ticks, always on; ready cannot come before about 40 cycles
      apb(1'b1, 8'h10, 32'h00002002);
      tick(2);
      chk("run enabled", 32'h1, {31'h0, osc_run_out});
      tick(20);
      rd_chk("ready early", 8'h0C, 32'h0);
      wait_ready();
      chk("ready set", 32'h1, rdata);
      apb(1'b1, 8'h00, 32'h1);
      tick(1);
      chk("irq raised", 32'h1, {31'h0, irq_out});
      apb(1'b1, 8'h08, 32'h0);
      tick(1);
      chk("flag kept", 32'h1, {31'h0, irq_out});
      apb(1'b1, 8'h08, 32'h1);
      rd_chk("flag cleared", 8'h08, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
      // On request and standby gating
      apb(1'b1, 8'h10, 32'h00002082);
      tick(5);
      chk("no request", 32'h0, {31'h0, osc_run_out});
      rd_chk("ready dropped", 8'h0C, 32'h0);
      req <= 1'b1;
      tick(5);
      chk("request", 32'h1, {31'h0, osc_run_out});
      stby <= 1'b1;
      tick(5);
      chk("standby stop", 32'h0, {31'h0, osc_run_out});
      apb(1'b1, 8'h10, 32'h000020C2);
      tick(5);
      chk("standby keep", 32'h1, {31'h0, osc_run_out});
      wait_ready();
      chk("ready again", 32'h1, {31'h0, irq_out});
      apb(1'b1, 8'h10, 32'h0);
      tick(3);
      rd_chk("disabled", 8'h0C, 32'h0);
      rd_chk("unmapped data", 8'h04, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, last_err});
      conclude();
   end
endmodule
